// file: hdl/xpoint_consts.vh
`ifndef XPOINT_CONSTS_VH
`define XPOINT_CONSTS_VH
`define WORD_BITS     80
`define GROUP_BITS    5
`define NUM_CH        16
`define SEL_BITS      4
`define EN_POS        4
`define SYNC_STAGES   2
`define PIN_SCLK      0
`define PIN_DIN       1
`define PIN_STB       2
`define PIN_CS        3
`define PIN_RST       4
`define NUM_PINS      5
`define PIN_IDLE      5'h1C
`endif

// file: hdl/latch_bank.v
`timescale 1ns/10ps
`include "xpoint_consts.vh"
// =====================================
// parallel configuration store, one entry per output channel
module latch_bank (
	input  wire                        core_clk,
	input  wire                        ce,
	input  wire                        load,
	input  wire [`WORD_BITS-1:0]       load_word,
	input  wire                        dis_all,
	output reg  [`NUM_CH-1:0]          en_q,
	output reg  [`NUM_CH*`SEL_BITS-1:0] sel_q
);
	genvar g;
	generate
		for (g = 0; g < `NUM_CH; g = g + 1) begin : ch
			// channel g sits at group g; channel 15 is the first group shifted in, so it sits deepest
			always @(posedge core_clk) begin
				if (ce) begin
					if (dis_all)
						en_q[g] <= 1'b0;
					else if (load)
						en_q[g] <= load_word[g*`GROUP_BITS+`EN_POS];
					if (load)
						sel_q[g*`SEL_BITS +: `SEL_BITS] <=
							load_word[g*`GROUP_BITS +: `SEL_BITS];
				end
			end
		end
	endgenerate
endmodule // latch_bank

// file: hdl/xpoint_ctrl.v
`timescale 1ns/10ps
`include "xpoint_consts.vh"
module xpoint_ctrl (
	input  wire                         core_clk,
	input  wire                         srst,
	input  wire                         clk_en,
	input  wire                         ser_clk,
	input  wire                         ser_in,
	input  wire                         strobe_n,
	input  wire                         chip_sel_n,
	input  wire                         reset_n,
	output reg                          ser_out,
	output wire [`NUM_CH-1:0]           out_enable_bit,
	output wire [`NUM_CH*`SEL_BITS-1:0] input_select_field,
	output reg  [`NUM_CH*`NUM_CH-1:0]   route_onehot
);
	// =====================================
	// freeze
	// clk_en low holds every register in the latch bank, and every one here unless srst is high;
	// the synchronisers stop too, so a pin pulse that comes and goes during a freeze is lost

	// =====================================
	// pin synchronisers
	// every pin is asynchronous to core_clk; the first stage is read only by the second
	localparam [`NUM_PINS-1:0] PIN_IDLE_V = `PIN_IDLE;

	wire [`NUM_PINS-1:0] pin_raw;
	reg  [`NUM_PINS-1:0] meta_q;
	reg  [`NUM_PINS-1:0] sync_q;

	assign pin_raw[`PIN_SCLK] = ser_clk;
	assign pin_raw[`PIN_DIN]  = ser_in;
	assign pin_raw[`PIN_STB]  = strobe_n;
	assign pin_raw[`PIN_CS]   = chip_sel_n;
	assign pin_raw[`PIN_RST]  = reset_n;

	genvar p;
	generate
		for (p = 0; p < `NUM_PINS; p = p + 1) begin : pin
			// reset to the idle level so release cannot look like a strobe or a select
			always @(posedge core_clk) begin
				if (srst) begin
					meta_q[p] <= PIN_IDLE_V[p];
					sync_q[p] <= PIN_IDLE_V[p];
				end else if (clk_en) begin
					meta_q[p] <= pin_raw[p];
					sync_q[p] <= meta_q[p];
				end
			end
		end
	endgenerate

	wire sclk_sync;
	wire din_sync;
	wire stb_n_sync;
	wire cs_n_sync;
	wire rst_n_sync;

	assign sclk_sync  = sync_q[`PIN_SCLK];
	assign din_sync   = sync_q[`PIN_DIN];
	assign stb_n_sync = sync_q[`PIN_STB];
	assign cs_n_sync  = sync_q[`PIN_CS];
	assign rst_n_sync = sync_q[`PIN_RST];

	// =====================================
	// serial clock edge finder
	// held low in reset: an idle-high clock then shows a rise, never a false fall
	// a clock phase shorter than about one core_clk cycle can slip past unseen
	reg sclk_prev_q;

	always @(posedge core_clk) begin
		if (srst) begin
			sclk_prev_q <= 1'b0;
		end else if (clk_en) begin
			sclk_prev_q <= sclk_sync;
		end
	end

	// strobe and shift both wait for the select, the reset pin does not
	wire selected;
	wire sclk_fall;
	wire shift_en;
	wire xfer;
	wire dis_all;

	assign selected  = ~cs_n_sync;
	assign sclk_fall = sclk_prev_q & ~sclk_sync;
	assign shift_en  = clk_en & sclk_fall & selected;
	assign xfer      = ~stb_n_sync & selected;
	assign dis_all   = ~rst_n_sync;                   // select does not matter

	// =====================================
	// shift register, one stage per bit
	// srst gives a known start for the chain; the reset pin never reaches it
	reg [`WORD_BITS-1:0] shift_q;

	genvar b;
	generate
		for (b = 0; b < `WORD_BITS; b = b + 1) begin : stage
			wire stage_in;
			if (b == 0) begin : head
				assign stage_in = din_sync;
			end else begin : link
				assign stage_in = shift_q[b-1];
			end
			// every detected fall while selected shifts; back-to-back bits need no idle cycles
			always @(posedge core_clk) begin
				if (srst) begin
					shift_q[b] <= 1'b0;
				end else if (shift_en) begin
					shift_q[b] <= stage_in;
				end
			end
		end
	endgenerate

	// =====================================
	// serial out
	// one cycle behind the last stage, so a chained part sees settled data
	always @(posedge core_clk) begin
		if (srst) begin
			ser_out <= 1'b0;
		end else if (clk_en) begin
			ser_out <= shift_q[`WORD_BITS-1];
		end
	end

	// =====================================
	// parallel latches
	// transparency is modelled as a copy every cycle while open; reset wins over a copy of the enables, select fields still copy
	wire latch_clear;

	assign latch_clear = dis_all | srst;

	latch_bank u_bank (
		.core_clk  (core_clk),
		.ce        (clk_en),
		.load      (xfer),
		.load_word (shift_q),
		.dis_all   (latch_clear),
		.en_q      (out_enable_bit),
		.sel_q     (input_select_field)
	);

	// =====================================
	// input decoder: exactly one point per code
	// every code is listed; the default only keeps the decode total
	function [`NUM_CH-1:0] decode_sel;
		input [`SEL_BITS-1:0] code;
		begin
			case (code)
				4'h0: decode_sel = 16'h0001;
				4'h1: decode_sel = 16'h0002;
				4'h2: decode_sel = 16'h0004;
				4'h3: decode_sel = 16'h0008;
				4'h4: decode_sel = 16'h0010;
				4'h5: decode_sel = 16'h0020;
				4'h6: decode_sel = 16'h0040;
				4'h7: decode_sel = 16'h0080;
				4'h8: decode_sel = 16'h0100;
				4'h9: decode_sel = 16'h0200;
				4'hA: decode_sel = 16'h0400;
				4'hB: decode_sel = 16'h0800;
				4'hC: decode_sel = 16'h1000;
				4'hD: decode_sel = 16'h2000;
				4'hE: decode_sel = 16'h4000;
				4'hF: decode_sel = 16'h8000;
				default: decode_sel = 16'h0000;
			endcase
		end
	endfunction

	// =====================================
	// one-hot crosspoint drive
	// a disabled output selects nothing, so its row stays all zero;
	// registered so the matrix never sees a half-updated decode
	genvar c;
	generate
		for (c = 0; c < `NUM_CH; c = c + 1) begin : route
			wire [`SEL_BITS-1:0] pick;
			wire                 live;
			wire [`NUM_CH-1:0]   row_d;

			assign pick  = input_select_field[c*`SEL_BITS +: `SEL_BITS];
			assign live  = out_enable_bit[c];
			assign row_d = live ? decode_sel(pick) : {`NUM_CH{1'b0}};

			always @(posedge core_clk) begin
				if (srst) begin
					route_onehot[c*`NUM_CH +: `NUM_CH] <= {`NUM_CH{1'b0}};
				end else if (clk_en) begin
					route_onehot[c*`NUM_CH +: `NUM_CH] <= row_d;
				end
			end
		end
	endgenerate
endmodule // xpoint_ctrl

// file: verif/xpoint_ctrl_properties.sv
`timescale 1ns/10ps
module xpoint_checker (
	input         core_clk, srst, ser_clk, strobe_n, chip_sel_n, reset_n, ser_out,
	input [15:0]  out_enable_bit,
	input [63:0]  input_select_field,
	input [255:0] route_onehot
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	rst_dis_a: assert property (!reset_n [*5] |-> !out_enable_bit) else $error("on");
	rst_sel_a: assert property ((!reset_n && strobe_n) [*4] |=> $stable(input_select_field))
		else $error("sel");
	cs_ser_a: assert property (chip_sel_n [*5] |=> $stable(ser_out)) else $error("ser");
	cs_latch_a: assert property ((chip_sel_n && reset_n) [*5] |=> $stable(route_onehot))
		else $error("lat");
	ser_edge_a: assert property ($changed(ser_out) |-> !ser_clk) else $error("edge");
	en_src_a: assert property ($changed(out_enable_bit) |-> !(reset_n && strobe_n &&
		$past(reset_n, 5) && $past(strobe_n, 5))) else $error("en");
	one_sel_a: assert property ($countones(route_onehot) ==
		$countones($past(out_enable_bit))) else $error("cnt");
	route_en_a: assert property (|route_onehot[255:240] == $past(out_enable_bit[15]))
		else $error("rt");
	cover property (!strobe_n);
	cover property (!reset_n);
	cover property (chip_sel_n);
endmodule // xpoint_checker

// file: verif/xpoint_host.sv
`timescale 1ns/10ps
module xpoint_host (
	output reg ser_clk, ser_in, strobe_n, chip_sel_n, reset_n
);
	integer i;
	initial {ser_clk, ser_in, strobe_n, chip_sel_n, reset_n} = 5'h1F;
	task send(input [79:0] w, input cs);
		chip_sel_n = cs;
		for (i = 79; i >= 0; i = i - 1) begin
			ser_in = w[i];
			#31 ser_clk = 1'b0;
			#62.5 ser_clk = 1'b1;
			#31.5;
		end
		ser_in = ~ser_in; // a released line must not echo the last bit
	endtask
	task pulse(input cs);
		chip_sel_n = cs;
		#100 strobe_n = 1'b0;
		#200 strobe_n = 1'b1;
		#100;
	endtask
	task set_reset(input level);
		reset_n = level;
		#100;
	endtask
endmodule // xpoint_host

// file: verif/tb.sv
`timescale 1ns/10ps
module tb;
	reg           core_clk = 1'b0;
	reg           srst = 1'b1;
	reg  [79:0]   w = 80'hF7A5_3C96_E1D2_4B87_7869;
	reg  [15:0]   x_en;
	reg  [63:0]   x_sel;
	reg  [255:0]  x_rt;
	integer       failures = 0, n_compared = 0, c;
	wire          ser_clk, ser_in, strobe_n, chip_sel_n, reset_n, ser_out;
	wire [15:0]   out_enable_bit;
	wire [63:0]   input_select_field;
	wire [255:0]  route_onehot;
	always #4 core_clk = ~core_clk;
	xpoint_host ctl (.ser_clk, .ser_in, .strobe_n, .chip_sel_n, .reset_n);
	xpoint_ctrl uut (.core_clk, .srst, .clk_en(1'b1), .ser_clk, .ser_in, .strobe_n, .chip_sel_n,
		.reset_n, .ser_out, .out_enable_bit, .input_select_field, .route_onehot);
	task check(input [255:0] seen, input [255:0] exp);
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("Error %0t %h %h", $time, seen, exp);
		end
	endtask
	task print_verdict;
		$display("failures %0d compared %0d", failures, n_compared);
		if (failures == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#100000;
		failures = failures + 1;
		print_verdict;
	end
	initial begin
		for (c = 0; c < 16; c = c + 1) begin
			x_en[c] = w[5*c+4];
			x_sel[4*c +: 4] = w[5*c +: 4];
			x_rt[16*c +: 16] = {15'h0, w[5*c+4]} << w[5*c +: 4];
		end
		repeat (3) @(negedge core_clk);
		srst = 1'b0;
		ctl.send(w, 1'b0);
		check(ser_out, w[79]);
		ctl.pulse(1'b0);
		check(out_enable_bit, x_en);
		check(input_select_field, x_sel);
		check(route_onehot, x_rt);
		ctl.send(~w, 1'b1);
		ctl.pulse(1'b1);
		check(route_onehot, x_rt);
		check(ser_out, w[79]);
		ctl.set_reset(1'b0);
		check(out_enable_bit, 16'h0);
		check(route_onehot, 256'h0);
		check(input_select_field, x_sel);
		ctl.set_reset(1'b1);
		ctl.pulse(1'b0);
		check(out_enable_bit, x_en);
		check(ser_out, w[79]);
		print_verdict;
	end
endmodule // tb
bind xpoint_ctrl xpoint_checker chk (.core_clk, .srst, .ser_clk, .strobe_n, .chip_sel_n,
	.reset_n, .ser_out, .out_enable_bit, .input_select_field, .route_onehot);
